// ==== src/slc_line_control.sv ====
/*
  Serial line control: registers, bit timing, framing both ways, line
  ends, flow control and DTR/RTS for a loop-bus to serial converter.
  Assumes an outside receive buffer that reports its free space and
  inputs synchronous to clk.
*/
//
// How it works
// - Enabled delete strips received code 127.
// - Auto DTR drops at reserve threshold.
// - Auto RTS follows transmit buffer occupancy.
// - Manual mode: bits 1,0 drive DTR, RTS.
// - Input status reads live handshake lines.
// - Stop count and data length from format.
// - Parity error forces forwarded bit 7 high.
// - Four-bit code selects bit rate.
// - Parity enable adds and checks parity bit.
// - Echo retransmits received characters; a newer one replaces a waiting echo.
// - Break holds line low, stops data.
// - Select bit one ignores its input line.
// - Line end removed, prior byte marked end.
// - End byte followed by inserted line end if detection also on.
// - Half duplex drops auto RTS on line end unless CTS is ignored.
// - Protocol register write releases transmit wait.
// - Receiver and transmitter flow control enables.
// - Prompt only for terminal transmitter protocol.
// - Pad code plus one nulls after line end.
// - Writes keep low nibble, reads show 0100.
// - Zero threshold or block size means 256.
`timescale 1ns/1ns
module slc_line_control
  import slc_pkg::*;
#(
  parameter int CLK_HZ = CLK_FREQ_HZ
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register command port
  input  wire logic       regWrEn,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // Character settings
  input  wire logic [7:0] eolDetect1,
  input  wire logic [7:0] eolDetect2,
  input  wire logic [7:0] eolInsert1,
  input  wire logic [7:0] eolInsert2,
  input  wire logic [7:0] promptChar,
  input  wire logic [7:0] readyChar,
  input  wire logic [7:0] notReadyChar,
  input  wire logic [7:0] requestChar,
  input  wire logic [7:0] answerChar,
  input  wire logic [7:0] blockSize,
  input  wire logic [7:0] rxReserve,
  // Receive buffer state
  input  wire logic [8:0] rxFreeBytes,
  input  wire logic       rxBufEmpty,
  // Loop side, outgoing serial data
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic       txEnd,
  output logic            txReady,
  // Loop side, received serial data
  output logic            rxOutValid,
  output logic      [7:0] rxOutData,
  output logic            rxOutEnd,
  // Serial lines
  input  wire logic       rxd,
  input  wire logic       ctsIn,
  input  wire logic       dcdIn,
  input  wire logic       dsrIn,
  output logic            txd,
  output logic            dtr,
  output logic            rts
);

  // ===========================================================
  // Control registers
  logic [3:0] delQ, outQ, fmtQ, rateQ, parQ, brkQ, eolQ, flowQ, padQ, rdNib;
  logic       flowWr;  // Any write to the protocol register

  assign flowWr = regWrEn && (regAddr == REG_FLOW_PROTOCOL);

  // Register writes keep only the low nibble
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      delQ  <= RST_SPECIAL_DELETE;
      outQ  <= RST_OUT_LINES;
      fmtQ  <= RST_WORD_FORMAT;
      rateQ <= RST_BIT_RATE;
      parQ  <= RST_PARITY_ECHO;
      brkQ  <= RST_BREAK_HANDSHK;
      eolQ  <= RST_LINE_END;
      flowQ <= RST_FLOW_PROTOCOL;
      padQ  <= RST_NULL_PAD;
    end else if (regWrEn) begin
      if (regAddr == REG_SPECIAL_DELETE) delQ <= regWrData[3:0];
      else if (regAddr == REG_OUT_LINES) outQ <= regWrData[3:0];
      else if (regAddr == REG_WORD_FORMAT) fmtQ <= regWrData[3:0];
      else if (regAddr == REG_BIT_RATE) rateQ <= regWrData[3:0];
      else if (regAddr == REG_PARITY_ECHO) parQ <= regWrData[3:0];
      else if (regAddr == REG_BREAK_HANDSHK) brkQ <= regWrData[3:0];
      else if (regAddr == REG_LINE_END) eolQ <= regWrData[3:0];
      else if (regAddr == REG_FLOW_PROTOCOL) flowQ <= regWrData[3:0];
      else if (regAddr == REG_NULL_PAD) padQ <= regWrData[3:0];
    end
  end

  // Low nibble of the addressed register; input status is never stored
  always_comb begin
    if (regAddr == REG_SPECIAL_DELETE) rdNib = delQ;
    else if (regAddr == REG_OUT_LINES) rdNib = outQ;
    else if (regAddr == REG_IN_LINES) rdNib = {1'b0, dsrIn, dcdIn, ctsIn};
    else if (regAddr == REG_WORD_FORMAT) rdNib = fmtQ;
    else if (regAddr == REG_BIT_RATE) rdNib = rateQ;
    else if (regAddr == REG_PARITY_ECHO) rdNib = parQ;
    else if (regAddr == REG_BREAK_HANDSHK) rdNib = brkQ;
    else if (regAddr == REG_LINE_END) rdNib = eolQ;
    else if (regAddr == REG_FLOW_PROTOCOL) rdNib = flowQ;
    else if (regAddr == REG_NULL_PAD) rdNib = padQ;
    else rdNib = 4'h0;  // Unserved numbers read as blank
  end

  // Readback one cycle after the address
  always_ff @(posedge clk) begin
    if (!rst_n) regRdData <= 8'h00;
    else regRdData <= {READ_UPPER, rdNib};
  end

  // ===========================================================
  // Bit timing and frame helpers
  logic [21:0] divTab [16];  // Clocks per bit for each rate code
  logic [21:0] bitDiv;
  logic        lineOn;       // Rate code zero parks both directions
  logic [3:0]  frameLen;     // Start + data + parity + stops

  for (genvar g = 0; g < 16; g++) begin : gRate
    assign divTab[g] = 22'(CLK_HZ / RATE_BPS[g]);
  end
  assign bitDiv   = divTab[rateQ];
  assign lineOn   = (rateQ != 4'h0);
  assign frameLen = 4'(1 + MIN_DATA_BITS + fmtQ[2:1] + parQ[PARITY_EN_BIT]
                      + 1 + fmtQ[STOP_TWO_BIT]);

  // Parity bit from a data sum
  function automatic logic parBit(input logic sum, input logic [1:0] kind);
    if (kind == PAR_ODD) return ~sum;
    else if (kind == PAR_EVEN) return sum;
    else return (kind == PAR_MARK);
  endfunction : parBit

  // Frame LSB first, unused tail left at idle ones
  function automatic logic [11:0] buildFrame(input logic [7:0] d, input logic [3:0] f,
                                             input logic [3:0] p);
    logic [11:0] fr;
    logic        sum;
    int          n;
    fr  = 12'hFFF;
    sum = 1'b0;
    n   = MIN_DATA_BITS + int'(f[2:1]);
    fr[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        fr[i + 1] = d[i];
        sum       = sum ^ d[i];
      end
    end
    if (p[PARITY_EN_BIT]) fr[n + 1] = parBit(sum, p[3:2]);
    return fr;
  endfunction : buildFrame

  // ===========================================================
  // Receiver framing
  slc_rx_state_t rxStateQ;
  logic [21:0]   rxCntQ;
  logic [3:0]    rxIdxQ;
  logic [11:0]   rxShiftQ;
  logic          rxDoneQ;
  logic          rxLineOk;

  assign rxLineOk = brkQ[IGN_DCD_BIT] | dcdIn;

  // Samples mid-bit; a start bit gone high again is noise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxStateQ <= RX_IDLE;
      rxCntQ   <= 22'h0;
      rxIdxQ   <= 4'h0;
      rxShiftQ <= 12'hFFF;
      rxDoneQ  <= 1'b0;
    end else begin
      rxDoneQ <= 1'b0;
      case (rxStateQ)
        RX_IDLE: begin
          if (lineOn && rxLineOk && !rxd) begin
            rxStateQ <= RX_START;
            rxCntQ   <= bitDiv >> 1;
          end
        end
        RX_START: begin
          if (rxCntQ != 22'h0) rxCntQ <= rxCntQ - 22'h1;
          else if (rxd) rxStateQ <= RX_IDLE;
          else begin
            rxStateQ    <= RX_BITS;
            rxCntQ      <= bitDiv - 22'h1;
            rxIdxQ      <= 4'h1;
            rxShiftQ[0] <= 1'b0;
          end
        end
        RX_BITS: begin
          if (rxCntQ != 22'h0) rxCntQ <= rxCntQ - 22'h1;
          else begin
            rxShiftQ[rxIdxQ] <= rxd;
            rxCntQ           <= bitDiv - 22'h1;
            rxIdxQ           <= rxIdxQ + 4'h1;
            if (rxIdxQ == frameLen - 4'h1) begin
              rxStateQ <= RX_IDLE;
              rxDoneQ  <= 1'b1;
            end
          end
        end
        default: rxStateQ <= RX_IDLE;
      endcase
    end
  end

  // Decode the finished frame
  logic [7:0] rxChar;
  logic       rxParErr, rxFrameErr, rxGood;
  always_comb begin
    logic sum;
    int   n, s;
    sum    = 1'b0;
    n      = MIN_DATA_BITS + int'(fmtQ[2:1]);
    s      = n + 1 + int'(parQ[PARITY_EN_BIT]);
    rxChar = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        rxChar[i] = rxShiftQ[i + 1];
        sum       = sum ^ rxShiftQ[i + 1];
      end
    end
    rxParErr   = parQ[PARITY_EN_BIT] && (rxShiftQ[n + 1] != parBit(sum, parQ[3:2]));
    rxFrameErr = !rxShiftQ[s] || (fmtQ[STOP_TWO_BIT] && !rxShiftQ[s + 1]);
    rxGood     = rxDoneQ && !rxFrameErr;  // Broken frames are dropped
  end

  // ===========================================================
  // Received character handling
  logic       txProtoHost, txProtoTerm, isAnswer, isRequest, isEol, isDel;
  logic [7:0] rxMarked;
  logic       holdValidQ;
  logic [7:0] holdQ;

  assign txProtoHost = flowQ[TX_PROTO_BIT] && flowQ[TX_HOST_BIT];
  assign txProtoTerm = flowQ[TX_PROTO_BIT] && !flowQ[TX_HOST_BIT];
  assign isAnswer    = txProtoHost && (rxChar == answerChar);
  assign isRequest   = txProtoTerm && (rxChar == requestChar);
  assign isDel       = delQ[DEL_RUBOUT_BIT] && (rxChar == DEL_CHAR);
  assign isEol       = ((eolDetect1 != 8'h00) && (rxChar == eolDetect1))
                       || (rxChar == eolDetect2);
  assign rxMarked    = {rxChar[7] | (fmtQ[SHOW_PERR_BIT] && parQ[PARITY_EN_BIT] && rxParErr),
                        rxChar[6:0]};

  // One byte held back so a line end can mark it as end byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      holdValidQ <= 1'b0;
      holdQ      <= 8'h00;
      rxOutValid <= 1'b0;
      rxOutData  <= 8'h00;
      rxOutEnd   <= 1'b0;
    end else begin
      rxOutValid <= 1'b0;
      if (rxGood && !isAnswer && !isRequest && !isDel) begin
        if (!eolQ[EOL_DETECT_BIT]) begin
          rxOutValid <= 1'b1;
          rxOutData  <= rxMarked;
          rxOutEnd   <= 1'b0;
        end else if (isEol) begin
          rxOutValid <= holdValidQ;
          rxOutData  <= holdQ;
          rxOutEnd   <= 1'b1;
          holdValidQ <= 1'b0;
        end else begin
          rxOutValid <= holdValidQ;
          rxOutData  <= holdQ;
          rxOutEnd   <= 1'b0;
          holdQ      <= rxMarked;
          holdValidQ <= 1'b1;
        end
      end else if (!eolQ[EOL_DETECT_BIT] && holdValidQ) begin
        // Detection off with a byte held: release it plain
        rxOutValid <= 1'b1;
        rxOutData  <= holdQ;
        rxOutEnd   <= 1'b0;
        holdValidQ <= 1'b0;
      end
    end
  end

  // ===========================================================
  // Transmit selection
  logic          txIdle, hwOk, loadEcho, loadCtrl, loadEol, loadData;
  logic [7:0]    loadChar;
  logic          echoPendQ, ctrlPendQ, waitAnswerQ, txBufFullQ, txBufEndQ, halfDropQ;
  logic [7:0]    echoCharQ, ctrlCharQ, txBufQ;
  slc_eol_state_t eolStateQ;
  logic [2:0]    nullCntQ;
  logic [11:0]   txShiftQ;
  logic [3:0]    txLeftQ;
  logic [21:0]   txCntQ;

  assign txIdle  = (txLeftQ == 4'h0) && lineOn && !brkQ[BREAK_BIT];
  assign hwOk    = (brkQ[IGN_CTS_BIT] | ctsIn) & (brkQ[IGN_DSR_BIT] | dsrIn);
  assign txReady = !txBufFullQ;

  // Priority: echo, flow character, line end, loop data
  always_comb begin
    loadEcho = 1'b0;
    loadCtrl = 1'b0;
    loadEol  = 1'b0;
    loadData = 1'b0;
    loadChar = NUL_CHAR;
    if (txIdle) begin
      if (echoPendQ) begin
        loadEcho = 1'b1;
        loadChar = echoCharQ;
      end else if (ctrlPendQ) begin
        loadCtrl = 1'b1;
        loadChar = ctrlCharQ;
      end else if (eolStateQ == EOL_FIRST) begin
        loadEol  = (eolInsert1 != 8'h00);
        loadChar = eolInsert1;
      end else if (eolStateQ == EOL_SECOND) begin
        loadEol  = 1'b1;
        loadChar = eolInsert2;
      end else if (eolStateQ == EOL_NULLS) begin
        loadEol  = 1'b1;
        loadChar = NUL_CHAR;
      end else if (txBufFullQ && hwOk && !waitAnswerQ) begin
        loadData = 1'b1;
        loadChar = txBufQ;
      end
    end
  end

  // Serial shifter; break forces the line low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txShiftQ <= 12'hFFF;
      txLeftQ  <= 4'h0;
      txCntQ   <= 22'h0;
      txd      <= 1'b1;
    end else begin
      txd <= brkQ[BREAK_BIT] ? 1'b0 : txShiftQ[0];
      if (loadEcho || loadCtrl || loadEol || loadData) begin
        txShiftQ <= buildFrame(loadChar, fmtQ, parQ);
        txLeftQ  <= frameLen;
        txCntQ   <= bitDiv - 22'h1;
      end else if (txLeftQ != 4'h0) begin
        if (txCntQ != 22'h0) txCntQ <= txCntQ - 22'h1;
        else begin
          txShiftQ <= {1'b1, txShiftQ[11:1]};
          txLeftQ  <= txLeftQ - 4'h1;
          txCntQ   <= bitDiv - 22'h1;
        end
      end
    end
  end

  // Loop data holding register (the transmit buffer)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txBufFullQ <= 1'b0;
      txBufQ     <= 8'h00;
      txBufEndQ  <= 1'b0;
    end else if (txValid && txReady) begin
      txBufFullQ <= 1'b1;
      txBufQ     <= txData;
      txBufEndQ  <= txEnd;
    end else if (loadData) begin
      txBufFullQ <= 1'b0;
    end
  end

  // Line end insertion sequence after an end byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eolStateQ <= EOL_NONE;
      nullCntQ  <= 3'h0;
    end else if (loadData) begin
      eolStateQ <= (txBufEndQ && eolQ[EOL_INSERT_BIT] && eolQ[EOL_DETECT_BIT])
                   ? EOL_FIRST : EOL_NONE;
    end else if (txIdle && !echoPendQ && !ctrlPendQ) begin
      if (eolStateQ == EOL_FIRST) eolStateQ <= EOL_SECOND;
      else if (eolStateQ == EOL_SECOND) begin
        eolStateQ <= padQ[NULL_EN_BIT] ? EOL_NULLS : EOL_NONE;
        nullCntQ  <= padQ[2:0];
      end else if (eolStateQ == EOL_NULLS) begin
        if (nullCntQ == 3'h0) eolStateQ <= EOL_NONE;
        else nullCntQ <= nullCntQ - 3'h1;
      end
    end
  end

  // ===========================================================
  // Echo and flow control characters
  logic [8:0] blockNeed, reserveNeed, sentCntQ;
  logic       notReadySentQ, answerOweQ;

  assign blockNeed   = (blockSize == 8'h00) ? ZERO_AS_SIZE : {1'b0, blockSize};
  assign reserveNeed = (rxReserve == 8'h00) ? ZERO_AS_SIZE : {1'b0, rxReserve};

  // Newest received character replaces a waiting echo
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      echoPendQ <= 1'b0;
      echoCharQ <= 8'h00;
    end else if (rxGood && parQ[ECHO_BIT]) begin
      echoPendQ <= 1'b1;
      echoCharQ <= rxChar;
    end else if (loadEcho) begin
      echoPendQ <= 1'b0;
    end
  end

  // Host waits for the answer per block; a protocol write frees it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sentCntQ    <= 9'h0;
      waitAnswerQ <= 1'b0;
    end else begin
      if (loadData && txProtoHost) sentCntQ <= sentCntQ + 9'h1;
      else if (loadCtrl && ctrlCharQ == requestChar) sentCntQ <= 9'h0;
      if (loadCtrl && txProtoHost && ctrlCharQ == requestChar) waitAnswerQ <= 1'b1;
      else if (flowWr || (rxGood && isAnswer)) waitAnswerQ <= 1'b0;
    end
  end

  // One pending flow character at a time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrlPendQ     <= 1'b0;
      ctrlCharQ     <= 8'h00;
      notReadySentQ <= 1'b0;
      answerOweQ    <= 1'b0;
    end else begin
      if (loadCtrl) ctrlPendQ <= 1'b0;
      else if (!ctrlPendQ) begin
        if (txProtoHost && sentCntQ >= blockNeed) begin
          ctrlPendQ <= 1'b1;
          ctrlCharQ <= requestChar;
        end else if (txProtoTerm && answerOweQ && rxFreeBytes >= blockNeed) begin
          ctrlPendQ  <= 1'b1;
          ctrlCharQ  <= flowQ[PROMPT_BIT] ? promptChar : answerChar;
          answerOweQ <= 1'b0;
        end else if (flowQ[RX_PROTO_BIT] && !notReadySentQ && rxFreeBytes <= reserveNeed) begin
          ctrlPendQ     <= 1'b1;
          ctrlCharQ     <= notReadyChar;
          notReadySentQ <= 1'b1;
        end else if (notReadySentQ && rxBufEmpty) begin
          ctrlPendQ     <= 1'b1;
          ctrlCharQ     <= readyChar;
          notReadySentQ <= 1'b0;
        end
      end
      if (rxGood && isRequest) answerOweQ <= 1'b1;  // Set wins
    end
  end

  // ===========================================================
  // Output handshake lines
  logic halfDuplexOk;
  assign halfDuplexOk = eolQ[HALF_DUPLEX_BIT] && !outQ[RTS_MANUAL_BIT] && !brkQ[IGN_CTS_BIT];

  // RTS drop holds until the next loop byte arrives
  always_ff @(posedge clk) begin
    if (!rst_n) halfDropQ <= 1'b0;
    else if (loadEol && halfDuplexOk) halfDropQ <= 1'b1;
    else if (txValid && txReady) halfDropQ <= 1'b0;
  end

  // DTR and RTS from manual bits or buffer state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dtr <= 1'b1;
      rts <= 1'b1;
    end else begin
      dtr <= outQ[DTR_MANUAL_BIT] ? outQ[DTR_LEVEL_BIT]
                                  : (rxFreeBytes > reserveNeed);
      rts <= outQ[RTS_MANUAL_BIT] ? outQ[RTS_LEVEL_BIT]
                                  : (txBufFullQ && !halfDropQ);
    end
  end

endmodule : slc_line_control

// ==== include/slc_pkg.sv ====
/*
  Constants for the serial line control block: register numbers, reset
  values, field positions, state codes and the bit-rate table.
  Assumes a single device clock; the clock rate is given here once.
*/
package slc_pkg;

  // ===========================================================
  // Register numbers on the command port
  localparam logic [3:0] REG_SPECIAL_DELETE = 4'h3;
  localparam logic [3:0] REG_OUT_LINES      = 4'h4;
  localparam logic [3:0] REG_IN_LINES       = 4'h5;
  localparam logic [3:0] REG_WORD_FORMAT    = 4'h6;
  localparam logic [3:0] REG_BIT_RATE       = 4'h7;
  localparam logic [3:0] REG_PARITY_ECHO    = 4'h8;
  localparam logic [3:0] REG_BREAK_HANDSHK  = 4'h9;
  localparam logic [3:0] REG_LINE_END       = 4'hA;
  localparam logic [3:0] REG_FLOW_PROTOCOL  = 4'hB;
  localparam logic [3:0] REG_NULL_PAD       = 4'hC;

  // ===========================================================
  // Reset values and readback pattern
  localparam logic [3:0] RST_SPECIAL_DELETE = 4'h0;
  localparam logic [3:0] RST_OUT_LINES      = 4'hF;
  localparam logic [3:0] RST_WORD_FORMAT    = 4'h0;
  localparam logic [3:0] RST_BIT_RATE       = 4'hE;
  localparam logic [3:0] RST_PARITY_ECHO    = 4'h0;
  localparam logic [3:0] RST_BREAK_HANDSHK  = 4'h7;
  localparam logic [3:0] RST_LINE_END       = 4'h0;
  localparam logic [3:0] RST_FLOW_PROTOCOL  = 4'hC;
  localparam logic [3:0] RST_NULL_PAD       = 4'h0;
  localparam logic [3:0] READ_UPPER         = 4'h4;

  // ===========================================================
  // Field positions
  localparam int DEL_RUBOUT_BIT  = 2;  // special_char_delete
  localparam int DTR_MANUAL_BIT  = 3;  // output_line_control
  localparam int RTS_MANUAL_BIT  = 2;
  localparam int DTR_LEVEL_BIT   = 1;
  localparam int RTS_LEVEL_BIT   = 0;
  localparam int STOP_TWO_BIT    = 3;  // word_format_select
  localparam int SHOW_PERR_BIT   = 0;
  localparam int PARITY_EN_BIT   = 1;  // parity_echo_control
  localparam int ECHO_BIT        = 0;
  localparam int BREAK_BIT       = 3;  // break_handshake_select
  localparam int IGN_DSR_BIT     = 2;
  localparam int IGN_DCD_BIT     = 1;
  localparam int IGN_CTS_BIT     = 0;
  localparam int EOL_DETECT_BIT  = 3;  // line_end_options
  localparam int EOL_INSERT_BIT  = 2;
  localparam int HALF_DUPLEX_BIT = 0;
  localparam int RX_PROTO_BIT    = 3;  // flow_protocol_select
  localparam int TX_PROTO_BIT    = 2;
  localparam int TX_HOST_BIT     = 1;
  localparam int PROMPT_BIT      = 0;
  localparam int NULL_EN_BIT     = 3;  // line_end_null_pad

  // ===========================================================
  // Characters, sizes and parity codes
  localparam logic [7:0] DEL_CHAR      = 8'h7F;
  localparam logic [7:0] NUL_CHAR      = 8'h00;
  localparam logic [8:0] ZERO_AS_SIZE  = 9'h100;
  localparam int         MIN_DATA_BITS = 5;
  localparam logic [1:0] PAR_ODD       = 2'h0;
  localparam logic [1:0] PAR_EVEN      = 2'h1;
  localparam logic [1:0] PAR_MARK      = 2'h2;

  // ===========================================================
  // Clock rate and bit-rate table; code 0 stops the line
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int RATE_BPS [16] = '{1, 50, 75, 110, 135, 150, 300, 600,
                                   1200, 1800, 2400, 3600, 4800, 7200, 9600, 19200};

  // ===========================================================
  // State codes
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } slc_rx_state_t;

  typedef enum logic [1:0] {
    EOL_NONE   = 2'b00,
    EOL_FIRST  = 2'b01,
    EOL_SECOND = 2'b10,
    EOL_NULLS  = 2'b11
  } slc_eol_state_t;

endpackage : slc_pkg

// ==== verif/slc_line_control_properties.sv ====
/* Port checker for slc_line_control.
   Assumes clk and a synchronous active-low rst_n. */
`timescale 1ns/1ns
module slc_line_control_properties
  import slc_pkg::*;
(
  // Clock, reset and register port
  input wire logic       clk, rst_n, regWrEn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData, regRdData, rxOutData, rxReserve,
  // Buffer state and lines
  input wire logic [8:0] rxFreeBytes,
  input wire logic       rxOutValid, ctsIn, dcdIn, dsrIn, txd, dtr, rts
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====
  // Shadow settings, updated with the block's own copies
  logic [3:0] outQ, brkQ, delQ;
  wire  [8:0] thr    = (rxReserve == 8'h00) ? ZERO_AS_SIZE : {1'b0, rxReserve};
  wire        dtrExp = rxFreeBytes > thr;
  wire  [3:0] wrNib  = regWrData[3:0];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outQ <= RST_OUT_LINES;
      brkQ <= RST_BREAK_HANDSHK;
      delQ <= RST_SPECIAL_DELETE;
    end else if (regWrEn) begin
      if (regAddr == REG_OUT_LINES) outQ <= wrNib;
      if (regAddr == REG_BREAK_HANDSHK) brkQ <= wrNib;
      if (regAddr == REG_SPECIAL_DELETE) delQ <= wrNib;
    end
  end
  chk_reset_lines_high: assert property ($rose(rst_n) |-> txd && dtr && rts)
    else $error("lines not high after reset");
  chk_read_upper_nibble: assert property ($past(rst_n) |-> regRdData[7:4] == READ_UPPER)
    else $error("readback upper nibble wrong");
  chk_write_low_nibble: assert property (regWrEn && regAddr == REG_BIT_RATE ##1
    regAddr == REG_BIT_RATE |=> regRdData == {READ_UPPER, $past(wrNib, 2)})
    else $error("written nibble not read back");
  chk_status_live_lines: assert property (regAddr == REG_IN_LINES |=>
    regRdData == {READ_UPPER, 1'b0, $past(dsrIn), $past(dcdIn), $past(ctsIn)})
    else $error("input status not live");
  chk_manual_dtr_level: assert property (outQ[3] |=> dtr == $past(outQ[1]))
    else $error("manual dtr level wrong");
  chk_auto_dtr_thresh: assert property (!outQ[3] |=> dtr == $past(dtrExp))
    else $error("automatic dtr wrong");
  chk_break_holds_low: assert property (brkQ[3] |=> !txd)
    else $error("break not on line");
  chk_delete_strips: assert property (rxOutValid && delQ[2] |-> rxOutData != DEL_CHAR)
    else $error("delete character forwarded");
  cover property (rxOutValid);
  cover property (brkQ[3] ##1 !txd);
  cover property (!outQ[3] && !dtr);
endmodule : slc_line_control_properties
bind slc_line_control slc_line_control_properties chk (.clk, .rst_n, .regWrEn, .regAddr,
  .regWrData, .regRdData, .rxOutData, .rxReserve, .rxFreeBytes, .rxOutValid, .ctsIn,
  .dcdIn, .dsrIn, .txd, .dtr, .rts);

// ==== verif/slc_terminal_model.sv ====
/* Serial terminal model: sends 8N1 frames on rxd, captures frames from txd.
   Assumes the bit time BITNS matches the block's selected rate. */
`timescale 1ns/1ns
module slc_terminal_model #(parameter int BITNS = 800) (
  // Serial lines
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] lastTx;   // Last captured frame
  int         gotCount; // Frames captured
  initial begin
    rxd = 1'b1;
    gotCount = 0;
  end
  // Send one frame, LSB first
  task automatic send(input logic [7:0] b);
    rxd = 1'b0;
    #BITNS;
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      #BITNS;
    end
    rxd = 1'b1;
    #BITNS;
  endtask : send
  // Capture at bit centres; a break counts as a frame too
  always begin
    @(negedge txd);
    #(BITNS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      lastTx[i] = txd;
      #BITNS;
    end
    gotCount++;
  end
endmodule : slc_terminal_model

// ==== verif/slc_line_control_test.sv ====
/* Self-checking bench for slc_line_control with a terminal model.
   Assumes CLK_HZ 1_920_000: code 15 gives 100 cycles per bit. */
`timescale 1ns/1ns
module slc_line_control_test
  import slc_pkg::*;
;
  logic clk = 0, rst_n = 0, regWrEn = 0, txValid = 0, txEnd = 0, rxBufEmpty = 0;
  logic ctsIn = 1, dcdIn = 0, dsrIn = 1, txd, dtr, rts, rxd, txReady, rxOutValid, rxOutEnd;
  logic [3:0] regAddr = 0;
  logic [7:0] regWrData = 0, txData = 0, ch = 8'h0D, rxReserve = 8'h08, regRdData, rxOutData;
  logic [8:0] rxFreeBytes = 9'h100;
  int bad_count = 0, cmp_count = 0;
  always #4 clk = ~clk;
  slc_line_control #(.CLK_HZ(1_920_000)) dut (.clk, .rst_n, .regWrEn, .regAddr, .regWrData,
    .regRdData, .eolDetect1(ch), .eolDetect2(ch), .eolInsert1(ch), .eolInsert2(ch),
    .promptChar(ch), .readyChar(ch), .notReadyChar(ch), .requestChar(ch), .answerChar(ch),
    .blockSize(ch), .rxReserve, .rxFreeBytes, .rxBufEmpty, .txValid, .txData, .txEnd,
    .txReady, .rxOutValid, .rxOutData, .rxOutEnd, .rxd, .ctsIn, .dcdIn, .dsrIn, .txd, .dtr, .rts);
  slc_terminal_model #(.BITNS(800)) term (.txd, .rxd);
  // ====
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    chk(regRdData, e);
  endtask : rd
  task automatic waitRx(input logic [7:0] e);
    for (int k = 0; k < 3000 && rxOutValid !== 1'b1; k++) @(negedge clk);
    chk(rxOutValid && !rxOutEnd ? rxOutData : ~e, e);
  endtask : waitRx
  task automatic waitTx(input logic [7:0] e);
    int n0;
    n0 = term.gotCount;
    for (int k = 0; k < 3000 && term.gotCount == n0; k++) @(negedge clk);
    chk(term.gotCount != n0 ? term.lastTx : ~e, e);
  endtask : waitTx
  // Reset values, unmapped read, nibble write; protocols then turned off
  task automatic t_regs();
    logic [3:0] ra [9] = '{3, 4, 6, 7, 8, 9, 10, 11, 12};
    logic [3:0] rv [9] = '{0, 15, 0, 14, 0, 7, 0, 12, 0};
    for (int i = 0; i < 9; i++) rd(ra[i], {READ_UPPER, rv[i]});
    rd(4'hD, 8'h40);
    wr(REG_BIT_RATE, 8'hFF);
    rd(REG_BIT_RATE, 8'h4F);
    wr(REG_FLOW_PROTOCOL, 8'h00);
  endtask : t_regs
  // Manual and automatic DTR/RTS, zero threshold, live status
  task automatic t_lines();
    wr(REG_OUT_LINES, 8'h0C);
    @(negedge clk);
    chk({dtr, rts}, 8'h00);
    wr(REG_OUT_LINES, 8'h00);
    rxFreeBytes = 9'h008;
    repeat (2) @(negedge clk);
    chk({dtr, rts}, 8'h00);
    rxFreeBytes = 9'h009;
    repeat (2) @(negedge clk);
    chk(dtr, 8'h01);
    rxReserve = 8'h00;
    rxFreeBytes = 9'h100;
    repeat (2) @(negedge clk);
    chk(dtr, 8'h00);
    wr(REG_IN_LINES, 8'h0F);
    rd(REG_IN_LINES, 8'h45);
  endtask : t_lines
  // Receive, delete, echo, transmit, break; no loop data while echoing
  task automatic t_serial();
    wr(REG_WORD_FORMAT, 8'h06);
    fork term.send(8'h41); waitRx(8'h41); join
    wr(REG_SPECIAL_DELETE, 8'h04);
    fork begin term.send(8'h7F); term.send(8'h42); end waitRx(8'h42); join
    wr(REG_PARITY_ECHO, 8'h01);
    term.send(8'h43);
    waitTx(8'h43);
    wr(REG_PARITY_ECHO, 8'h00);
    {txValid, txData} = {1'b1, 8'h55};
    @(negedge clk);
    txValid = 1'b0;
    @(negedge clk);
    chk({txReady, rts}, 8'h01);
    waitTx(8'h55);
    wr(REG_BREAK_HANDSHK, 8'h0F);
    repeat (2) @(negedge clk);
    chk(txd, 8'h00);
  endtask : t_serial
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_lines();
    t_serial();
    summarize();
  end
  initial begin
    #400_000;
    bad_count++;
    summarize();
  end
endmodule : slc_line_control_test
